// >>> hdl/health_log_cfg.svh
// offsets, field positions, fixed values and register map of the health sector builder
`ifndef HEALTH_LOG_CFG_SVH
`define HEALTH_LOG_CFG_SVH

// common sector geometry
`define SEC_LAST_IDX 9'h1FF
`define SEC_ENT_FIRST 9'h002
`define SEC_ENT_END 9'h16A
`define SEC_ENT_BYTES 4'hB
`define SEC_SLOTS 30
`define STRUCT_REV 16'h0010

// attribute values sector fields
`define VAL_SELFTEST 9'h16B
`define VAL_CTIME_LO 9'h16C
`define VAL_CTIME_HI 9'h16D
`define VAL_COLLECT_CAP 9'h16F
`define VAL_CAP_LO 9'h170
`define VAL_CAP_HI 9'h171
`define VAL_ERRLOG_CAP 9'h172
`define VAL_CHECKPOINT 9'h173
`define VAL_SHORT_MIN 9'h174
`define VAL_EXT_MIN 9'h175
`define CAP_WORD 16'h0003
`define ERRLOG_CAP 8'h01
`define REMAIN_MAX 4'h9

// log directory and summary error log
`define LOG_VERSION 16'h0001
`define LOG_HOST_FIRST 8'h80
`define LOG_HOST_LAST 8'h9F
`define LOG_HOST_SECTORS 8'h10
`define LOG_SUMMARY_ADDR 8'h01
`define ERR_VERSION 8'h01
`define ERR_PTR_OFF 9'h001
`define ERR_REC_FIRST 9'h002
`define ERR_REC_BYTES 7'h5A
`define ERR_REC_COUNT 3'h5
`define ERR_AREA_BYTES 9'h1C2
`define ERR_CNT_LO 9'h1C4
`define ERR_CNT_HI 9'h1C5
`define ERR_CMD_BYTES 7'h0C
`define ERR_SNAP_OFF 7'h3C

// self-test outcome codes
`define ST_DONE 4'h0
`define ST_FATAL 4'h3
`define ST_READ_FAIL 4'h7
`define ST_RUNNING 4'hF

// register word indices (byte address = 4 * index)
`define REG_CTRL 6'h00
`define REG_SELFTEST 6'h01
`define REG_CTIME 6'h02
`define REG_CAPS 6'h03
`define REG_TIMES 6'h04
`define REG_ERR_ADDR 6'h05
`define REG_ERR_DATA 6'h06
`define REG_ERR_LOG 6'h07
`define REG_ATTR_VAL 6'h08
`define CTRL_START_BIT 4
`define CTRL_BUSY_BIT 8

`endif

// >>> hdl/health_log_pkg.sv
// types shared by the health sector builder
`default_nettype none
package health_log_pkg;

  typedef enum logic [1:0] {
    SEC_VALUES,
    SEC_THRESH,
    SEC_LOGDIR,
    SEC_ERRLOG
  } sector_sel_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] word;
    logic [31:0] wdata;
    logic [3:0] be;
  } bus_req_t;

  typedef struct packed {
    logic wait_n;
    logic ack;
    logic [31:0] rdata;
    sector_sel_t sel;
    logic busy;
    logic valid;
    logic last;
    logic [8:0] idx;
    logic [5:0] ent;
    logic [3:0] off;
    logic [7:0] sum;
    logic [7:0] data;
    logic [3:0] st_rem;
    logic [3:0] st_code;
    logic [15:0] ctime;
    logic abort_mode;
    logic [7:0] checkpoint;
    logic [7:0] short_min;
    logic [7:0] ext_min;
    logic [2:0] err_rec;
    logic [6:0] err_off;
    logic [2:0] err_ptr;
    logic [15:0] err_cnt;
    logic [239:0] vals;
  } state_t;

endpackage
`default_nettype wire

// >>> hdl/health_log_sector_builder.sv
// health status sector builder: avalon-mm registers in, 512-byte sectors out
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "health_log_cfg.svh"

module health_log_sector_builder
  import health_log_pkg::*;
#(
  parameter int ACTIVE_SLOTS = 17,
  parameter logic [239:0] THRESH_TABLE = {30{8'h10}}
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic sec_ready_in,
  output logic [7:0] sec_data_out,
  output logic sec_valid_out,
  output logic sec_last_out,
  output logic sec_busy_out
);

  // the id table below knows seventeen active attributes and a sector has thirty slots
  if (ACTIVE_SLOTS < 1 || ACTIVE_SLOTS > 17) begin : g_bad_slots
    $error("ACTIVE_SLOTS must lie in 1..17");
  end

  localparam logic [8:0] ERR_AREA = `ERR_AREA_BYTES;

  state_t s_q;
  state_t s_d;
  bus_req_t req;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [7:0] err_mem [0:449];
  logic [449:0] mem_set_q;
  logic mem_we;
  logic [8:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [8:0] mem_raddr;
  logic [7:0] mem_rdata;

  // attribute ids, one fixed list so values and thresholds share the order
  function automatic logic [7:0] attr_id(input logic [5:0] ent);
    logic [7:0] id;
    case (ent)
      6'h00: id = 8'h01;
      6'h01: id = 8'h02;
      6'h02: id = 8'h03;
      6'h03: id = 8'h04;
      6'h04: id = 8'h05;
      6'h05: id = 8'h07;
      6'h06: id = 8'h08;
      6'h07: id = 8'h09;
      6'h08: id = 8'h0A;
      6'h09: id = 8'h0C;
      6'h0A: id = 8'hC0;
      6'h0B: id = 8'hC1;
      6'h0C: id = 8'hC2;
      6'h0D: id = 8'hC4;
      6'h0E: id = 8'hC5;
      6'h0F: id = 8'hC6;
      6'h10: id = 8'hC7;
      default: id = 8'h00;
    endcase
    if (32'(ent) >= ACTIVE_SLOTS) begin
      id = 8'h00;
    end
    return id;
  endfunction

  // register read view, also the base for byte-enable merges on write
  function automatic logic [31:0] reg_view(input state_t s, input logic [5:0] word);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (word)
      `REG_CTRL: begin
        v[1:0] = s.sel;
        v[`CTRL_BUSY_BIT] = s.busy;
      end
      `REG_SELFTEST: v[7:0] = {s.st_code, s.st_rem};
      `REG_CTIME: v[15:0] = s.ctime;
      `REG_CAPS: v[0] = s.abort_mode;
      `REG_TIMES: v[23:0] = {s.checkpoint, s.ext_min, s.short_min};
      `REG_ERR_ADDR: v[10:0] = {s.err_rec, 1'b0, s.err_off};
      `REG_ERR_LOG: v = {s.err_cnt, 13'h0000, s.err_ptr};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // byte at position i of the selected sector; thresholds come only from the parameter
  function automatic logic [7:0] sector_byte(input state_t s, input logic [7:0] mem_byte);
    logic [7:0] b;
    logic [7:0] id;
    logic [7:0] log_addr;
    logic in_ent;
    b = 8'h00;
    id = attr_id(s.ent);
    log_addr = s.idx[8:1];
    in_ent = (s.idx >= `SEC_ENT_FIRST) && (s.idx < `SEC_ENT_END);
    case (s.sel)
      SEC_VALUES: begin
        if (s.idx == 9'h000) begin
          b = 8'(`STRUCT_REV & 16'h00FF);
        end else if (s.idx == 9'h001) begin
          b = 8'(`STRUCT_REV >> 8);
        end else if (in_ent) begin
          if (s.off == 4'h0) begin
            b = id;
          end else if (s.off == 4'h3 && id != 8'h00) begin
            b = s.vals[8*s.ent[4:0] +: 8];
          end
        end else begin
          case (s.idx)
            `VAL_SELFTEST: b = {s.st_code, s.st_rem};
            `VAL_CTIME_LO: b = s.ctime[7:0];
            `VAL_CTIME_HI: b = s.ctime[15:8];
            `VAL_COLLECT_CAP: b = {3'b000, 1'b1, 1'b1, s.abort_mode, 1'b1, 1'b1};
            `VAL_CAP_LO: b = 8'(`CAP_WORD & 16'h00FF);
            `VAL_CAP_HI: b = 8'(`CAP_WORD >> 8);
            `VAL_ERRLOG_CAP: b = `ERRLOG_CAP;
            `VAL_CHECKPOINT: b = s.checkpoint;
            `VAL_SHORT_MIN: b = s.short_min;
            `VAL_EXT_MIN: b = s.ext_min;
            default: b = 8'h00;
          endcase
        end
      end
      SEC_THRESH: begin
        if (s.idx == 9'h000) begin
          b = 8'(`STRUCT_REV & 16'h00FF);
        end else if (s.idx == 9'h001) begin
          b = 8'(`STRUCT_REV >> 8);
        end else if (in_ent) begin
          if (s.off == 4'h0) begin
            b = id;
          end else if (s.off == 4'h1 && id != 8'h00) begin
            b = THRESH_TABLE[8*s.ent[4:0] +: 8];
          end
        end
        // reserved and vendor area stays zero
      end
      SEC_LOGDIR: begin
        // version word, then count and reserved per address
        if (s.idx == 9'h000) begin
          b = 8'(`LOG_VERSION & 16'h00FF);
        end else if (s.idx == 9'h001) begin
          b = 8'(`LOG_VERSION >> 8);
        end else if (!s.idx[0]) begin
          if (log_addr >= `LOG_HOST_FIRST && log_addr <= `LOG_HOST_LAST) begin
            b = `LOG_HOST_SECTORS;
          end else if (log_addr == `LOG_SUMMARY_ADDR) begin
            b = 8'h01;
          end
        end
      end
      default: begin
        if (s.idx == 9'h000) begin
          b = `ERR_VERSION;
        end else if (s.idx == `ERR_PTR_OFF) begin
          b = {5'b00000, s.err_ptr};
        end else if (s.idx < `ERR_REC_FIRST + ERR_AREA) begin
          b = mem_byte;
        end else if (s.idx == `ERR_CNT_LO) begin
          b = s.err_cnt[7:0];
        end else if (s.idx == `ERR_CNT_HI) begin
          b = s.err_cnt[15:8];
        end
      end
    endcase
    return b;
  endfunction

  // reset release through two flops; the assert stays asynchronous
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // bus signals gathered into one carrier
  always_comb begin
    req.read = avs_read_in;
    req.write = avs_write_in & ~avs_read_in;
    req.word = avs_address_in[7:2];
    req.wdata = avs_writedata_in;
    req.be = avs_byteenable_in;
  end

  // error record memory, asynchronous read keeps the stream one byte per cycle
  always_ff @(posedge ref_clk_in) begin
    if (mem_we) begin
      err_mem[mem_waddr] <= mem_wdata;
    end
  end
  // written flags: a record byte never written reads as zero, not as stale or unknown content
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_set_q <= '0;
    end else if (mem_we) begin
      mem_set_q[mem_waddr] <= 1'b1;
    end
  end
  assign mem_rdata = (mem_raddr < ERR_AREA && mem_set_q[mem_raddr]) ? err_mem[mem_raddr] : 8'h00;

  // next state: bus slave, register writes, sector stream
  always_comb begin
    logic [31:0] wd;
    logic [31:0] mask;
    logic start;
    logic load;
    s_d = s_q;
    wd = 32'h0000_0000;
    mask = 32'h0000_0000;
    start = 1'b0;
    load = 1'b0;
    mem_we = 1'b0;
    mem_waddr = 9'h000;
    mem_wdata = 8'h00;
    // one wait cycle, then the answer stands for one cycle
    s_d.ack = (req.read | req.write) & ~s_q.ack;
    s_d.wait_n = s_d.ack;
    if (req.read && !s_q.ack) begin
      s_d.rdata = reg_view(s_q, req.word);
    end
    for (int k = 0; k < 4; k++) begin
      mask[8*k +: 8] = {8{req.be[k]}};
    end
    wd = (reg_view(s_q, req.word) & ~mask) | (req.wdata & mask);
    // a write lands on the edge where waitrequest is seen low
    if (req.write && s_q.ack) begin
      case (req.word)
        `REG_CTRL: begin
          if (!s_q.busy) begin
            s_d.sel = sector_sel_t'(wd[1:0]);
            start = wd[`CTRL_START_BIT];
          end
        end
        `REG_SELFTEST: begin
          s_d.st_rem = (wd[3:0] > `REMAIN_MAX) ? `REMAIN_MAX : wd[3:0];
          s_d.st_code = (wd[7:4] > `ST_READ_FAIL && wd[7:4] != `ST_RUNNING) ? `ST_FATAL : wd[7:4];
        end
        `REG_CTIME: s_d.ctime = wd[15:0];
        `REG_CAPS: s_d.abort_mode = wd[0];
        `REG_TIMES: begin
          s_d.short_min = wd[7:0];
          s_d.ext_min = wd[15:8];
          s_d.checkpoint = wd[23:16];
        end
        `REG_ERR_ADDR: begin
          s_d.err_rec = (wd[10:8] < `ERR_REC_COUNT) ? wd[10:8] : 3'h0;
          s_d.err_off = (wd[6:0] < `ERR_REC_BYTES) ? wd[6:0] : 7'h00;
        end
        `REG_ERR_DATA: begin
          // flat record byte; commands at 0..3Bh, error snapshot from 3Ch
          mem_we = 1'b1;
          mem_waddr = 9'({6'b000000, s_q.err_rec} * 9'd90) + {2'b00, s_q.err_off};
          mem_wdata = wd[7:0];
          s_d.err_off = (s_q.err_off == `ERR_REC_BYTES - 7'h01) ? 7'h00 : s_q.err_off + 7'h01;
        end
        `REG_ERR_LOG: begin
          if (wd[0]) begin
            // newest record pointer wraps 5 to 1
            s_d.err_ptr = (s_q.err_ptr >= `ERR_REC_COUNT || s_q.err_ptr == 3'h0) ? 3'h1 : s_q.err_ptr + 3'h1;
            s_d.err_cnt = (s_q.err_cnt == 16'hFFFF) ? s_q.err_cnt : s_q.err_cnt + 16'h0001;
          end
        end
        `REG_ATTR_VAL: begin
          if (wd[4:0] < 5'(`SEC_SLOTS)) begin
            s_d.vals[8*wd[4:0] +: 8] = wd[15:8];
          end
        end
        default: ;
      endcase
    end
    // stream the whole sector, byte by byte
    if (s_q.valid && sec_ready_in) begin
      if (s_q.last) begin
        s_d.valid = 1'b0;
        s_d.busy = 1'b0;
        s_d.last = 1'b0;
      end else begin
        load = 1'b1;
        s_d.idx = s_q.idx + 9'h001;
        // running sum of the bytes actually sent
        s_d.sum = s_q.sum + s_q.data;
        if (s_q.idx >= `SEC_ENT_FIRST) begin
          if (s_q.off == `SEC_ENT_BYTES) begin
            s_d.off = 4'h0;
            s_d.ent = s_q.ent + 6'h01;
          end else begin
            s_d.off = s_q.off + 4'h1;
          end
        end
      end
    end
    if (start) begin
      load = 1'b1;
      s_d.busy = 1'b1;
      s_d.valid = 1'b1;
      s_d.idx = 9'h000;
      s_d.ent = 6'h00;
      s_d.off = 4'h0;
      s_d.sum = 8'h00;
    end
    mem_raddr = s_d.idx - `ERR_REC_FIRST;
    // a held byte stays put until taken, so late field changes wait for the next byte
    if (load) begin
      s_d.last = (s_d.idx == `SEC_LAST_IDX);
      if (s_d.last) begin
        // two's complement makes the sector sum zero
        s_d.data = 8'h00 - s_d.sum;
      end else begin
        s_d.data = sector_byte(s_d, mem_rdata);
      end
    end
  end

  // all state but the reset flops, the error memory and its written flags in one register
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.sel <= SEC_VALUES;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = ~s_q.wait_n;
  assign sec_data_out = s_q.data;
  assign sec_valid_out = s_q.valid;
  assign sec_last_out = s_q.last;
  assign sec_busy_out = s_q.busy;

endmodule

`default_nettype wire

// >>> test/health_host_reader.sv
// host-side reader model that takes sector bytes, with optional stalls
`timescale 1ns/1ps
`default_nettype none
module health_host_reader (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic valid_in,
  output logic ready_out,
  output logic take_out
);
  logic [7:0] lf_q = 8'hA5;
  // stall pattern; an lfsr never sticks at zero, so stalls stay short
  always @(posedge clk_in) begin
    lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
  end
  // whole sector read
  // ready is never withdrawn for good, so every byte up to the checksum is taken
  assign ready_out = !slow_in | lf_q[0];
  assign take_out = valid_in & ready_out;
endmodule
`default_nettype wire

// >>> test/health_log_sector_builder_assertions.sv
// port checker for the health sector builder
`timescale 1ns/1ps
`default_nettype none
module health_log_checker (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic sec_ready_in,
  input wire logic [7:0] sec_data_out,
  input wire logic sec_valid_out,
  input wire logic sec_last_out,
  input wire logic sec_busy_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  logic take;
  logic [7:0] sum_q;
  logic [8:0] cnt_q;
  assign take = sec_valid_out & sec_ready_in;
  // running sum and count of taken bytes, cleared by the checksum byte
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sum_q <= 8'h00;
      cnt_q <= 9'h000;
    end else if (take) begin
      sum_q <= sec_last_out ? 8'h00 : sum_q + sec_data_out;
      cnt_q <= sec_last_out ? 9'h000 : cnt_q + 9'h001;
    end
  end
  sequence s_req;
    (avs_read_in | avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  chk_bus_answer:
    assert property (s_req |=> s_ans) else $error("bus answer late or long");
  chk_byte_hold:
    assert property (sec_valid_out && !sec_ready_in |=> sec_valid_out && $stable(sec_data_out) && $stable(sec_last_out))
    else $error("byte changed while stalled");
  chk_sum_zero:
    assert property (take && sec_last_out |-> 8'(sum_q + sec_data_out) == 8'h00) else $error("sector sum not zero");
  chk_last_pos:
    assert property (take |-> sec_last_out == (cnt_q == 9'h1FF)) else $error("last not on byte 511");
  chk_end_drop:
    assert property (take && sec_last_out |=> !sec_valid_out && !sec_busy_out && !sec_last_out)
    else $error("stream did not end");
  chk_valid_busy:
    assert property (sec_valid_out |-> sec_busy_out) else $error("valid outside transfer");
  chk_start_byte:
    assert property ($rose(sec_busy_out) |-> sec_valid_out && !sec_last_out && cnt_q == 9'h000)
    else $error("bad sector start");
  chk_next_byte:
    assert property (take && !sec_last_out |=> sec_valid_out) else $error("gap inside sector");
endmodule
`default_nettype wire

// >>> test/test_health_log_sector_builder.sv
// self-checking bench for the health sector builder
`timescale 1ns/1ps
`default_nettype none
module test_health_log_sector_builder;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic slow = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, r, v;
  logic [31:0] seed = 32'h0000_0037;
  logic wait_r, ready, valid, last, busy, take;
  logic [7:0] data;
  logic [7:0] rxq[$];
  int failures = 0;
  int n_checks = 0;
  int code, rem, ctime, abrt, tms, ptr, cnt;
  int vals[17];
  int err[450];
  int exp[512];
  int ids[17] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12, 192, 193, 194, 196, 197, 198, 199};

  always #5 ref_clk_in = ~ref_clk_in;

  health_log_sector_builder u_health_log_sector_builder (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
    .sec_ready_in(ready), .sec_data_out(data), .sec_valid_out(valid), .sec_last_out(last),
    .sec_busy_out(busy));
  health_host_reader u_health_host_reader (.clk_in(ref_clk_in), .slow_in(slow), .valid_in(valid),
    .ready_out(ready), .take_out(take));

  // capture every byte the host takes
  always @(posedge ref_clk_in) begin
    if (take === 1'b1) rxq.push_back(data);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input int wd, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr <= 8'(wd * 4);
    rd <= !w;
    wr <= w;
    wdata <= d;
    do @(posedge ref_clk_in); while (wait_r !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // expected sector from the model state
  task automatic build(input int sel);
    int s;
    s = 0;
    exp = '{default: 0};
    exp[0] = sel > 1 ? 1 : 16;
    if (sel < 2) for (int k = 0; k < 17; k++) begin
      exp[2 + 12 * k] = ids[k];
      exp[(sel ? 3 : 5) + 12 * k] = sel ? 16 : vals[k];
    end
    if (sel == 0) begin
      exp[9'h16B] = code * 16 + rem;
      exp[9'h16C] = ctime % 256;
      exp[9'h16D] = ctime / 256;
      exp[9'h16F] = 27 + 4 * abrt;
      exp[9'h170] = 3;
      exp[9'h172] = 1;
      exp[9'h173] = (tms >> 16) & 255;
      exp[9'h174] = tms & 255;
      exp[9'h175] = (tms >> 8) & 255;
    end
    if (sel == 2) begin
      exp[2] = 1;
      for (int a = 128; a < 160; a++) exp[2 * a] = 16;
    end
    if (sel == 3) begin
      exp[1] = ptr;
      for (int i = 0; i < 450; i++) exp[2 + i] = err[i];
      exp[9'h1C4] = cnt % 256;
      exp[9'h1C5] = cnt / 256;
    end
    for (int i = 0; i < 511; i++) s += exp[i];
    exp[511] = (256 - s % 256) % 256;
  endtask

  // start a sector, try a refused restart, then compare every byte
  task automatic sector(input int sel);
    int n;
    n = 0;
    build(sel);
    rxq.delete();
    bus(1, 0, 32'(16 + sel));
    bus(1, 0, 32'(16 + (sel ^ 1)));
    bus(0, 0, 0);
    check(r, 32'(256 + sel), "busy ctrl");
    while (rxq.size() < 512 && n < 3000) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (4) @(posedge ref_clk_in);
    check(rxq.size(), 512, "sector length");
    foreach (rxq[i]) if (i < 512) check(rxq[i], exp[i], "sector byte");
    $display("sector %0d done", sel);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    for (int w = 0; w < 10; w++) begin
      bus(0, w, 0);
      check(r, 0, "reset value");
    end
    $display("reset values done");
    for (int c = 0; c < 16; c++) begin
      bus(1, 1, 32'(c * 16 + 12));
      bus(0, 1, 0);
      check(r, 32'(((c > 7 && c < 15) ? 3 : c) * 16 + 9), "selftest");
    end
    $display("selftest codes done");
    for (int k = 0; k < 20; k++) begin
      v = rnd();
      bus(1, 8, (v & 32'h0000_FF00) | k);
      if (k < 17) vals[k] = v[15:8];
    end
    v = rnd();
    bus(1, 2, v);
    ctime = v[15:0];
    v = rnd();
    be <= 4'h1;
    bus(1, 2, v);
    be <= 4'hF;
    ctime = (ctime & 32'h0000_FF00) | v[7:0];
    bus(0, 2, 0);
    check(r, 32'(ctime), "byte enable");
    $display("byte enables done");
    bus(1, 3, v);
    abrt = v[0];
    bus(1, 4, v);
    tms = v[23:0];
    bus(1, 1, 32'h0000_0075);
    code = 7;
    rem = 5;
    slow <= 1'b1;
    sector(0);
    slow <= 1'b0;
    sector(1);
    sector(2);
    bus(1, 5, 32'h0000_0458);
    for (int i = 0; i < 3; i++) begin
      v = rnd();
      bus(1, 6, v);
      err[i < 2 ? 448 + i : 360] = v[7:0];
    end
    for (int j = 0; j < 7; j++) begin
      bus(1, 7, 32'(j > 0));
      if (j > 0) ptr = ptr == 5 ? 1 : ptr + 1;
      if (j > 0) cnt++;
      bus(0, 7, 0);
      check(r, 32'(cnt * 65536 + ptr), "error log");
    end
    sector(3);
    tally_and_finish();
  end

  // watchdog well beyond the expected run
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
endmodule

bind health_log_sector_builder health_log_checker u_health_log_checker (.ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .sec_ready_in(sec_ready_in), .sec_data_out(sec_data_out),
  .sec_valid_out(sec_valid_out), .sec_last_out(sec_last_out), .sec_busy_out(sec_busy_out));
`default_nettype wire
